// ---- shared/ppc_defs.svh ----
/*
 * Constants for the preset/protect control block: AHB register offsets,
 * field positions, reset values and timing counts.
 * Assumes inclusion by bare name from package and design files.
 */
`ifndef PPC_DEFS_SVH
`define PPC_DEFS_SVH

`define PPC_OFF_CTRL      8'h00
`define PPC_OFF_STATUS    8'h04
`define PPC_OFF_IRQ_STAT  8'h08
`define PPC_OFF_IRQ_MASK  8'h0C
`define PPC_OFF_WIPER0    8'h10
`define PPC_OFF_WIPER1    8'h14
`define PPC_OFF_NV0       8'h18
`define PPC_OFF_NV1       8'h1C
`define PPC_OFF_LAST_WORD 8'h20

`define PPC_WORD_BITS     24
`define PPC_CODE_BITS     10
`define PPC_MIDSCALE      10'h200
`define PPC_ADDR_CH0      4'h0
`define PPC_ADDR_CH1      4'h1

`define PPC_CMD_NOP       4'h0
`define PPC_CMD_RESTORE1  4'h1
`define PPC_CMD_STORE     4'h2
`define PPC_CMD_WR_NV     4'h3
`define PPC_CMD_RESTORE8  4'h8
`define PPC_CMD_READ_NV   4'h9
`define PPC_CMD_READ_WIP  4'hA
`define PPC_CMD_WRITE     4'hB

// irq status bit positions
`define PPC_IRQ_WORD      0
`define PPC_IRQ_PRESET    1
`define PPC_IRQ_DONE      2
`define PPC_IRQ_BLOCKED   3

// ctrl bit positions
`define PPC_CTRL_DONE_NOW 0

`define PPC_NV_WRITE_NS   1000
`define PPC_CLK_NS        5
`define PPC_NV_WRITE_CYC  ((`PPC_NV_WRITE_NS + `PPC_CLK_NS - 1) / `PPC_CLK_NS)

`endif

// ---- shared/ppc_pkg.sv ----
/*
 * Types for the preset/protect control block.
 * Assumes ppc_defs.svh is on the include path.
 */
`default_nettype none
`include "ppc_defs.svh"

package ppc_pkg;

  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [5:0] spare;
    logic [9:0] data;
  } ppc_word_t;

  typedef enum logic [1:0] {
    PPC_IDLE,
    PPC_BUSY
  } ppc_state_t;

endpackage

`default_nettype wire

// ---- src/ppc_sync.sv ----
/*
 * Two-flop synchroniser for one level from outside the core clock.
 * Assumes an asynchronous active-low reset with a chosen idle level.
 */
`timescale 1ns/10ps
`default_nettype none

module ppc_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_d,
  output var  logic o_q
);

  logic meta;
  logic next_meta;
  logic next_q;

  always_comb begin
    next_meta = i_d;
    next_q    = meta;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= RST_VAL;
      o_q  <= RST_VAL;
    end else begin
      meta <= next_meta;
      o_q  <= next_q;
    end
  end

endmodule

`default_nettype wire

// ---- src/ppc_top.sv ----
/*
 * Preset/protect/select/ready control of a dual-channel digital pot,
 * with an AHB-Lite register slave and one level interrupt.
 * Assumes pins come from outside the core clock; all are synchronised.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ppc_defs.svh"

// Overview of operation
// - protect low blocks every stored or register change except preset reload and restore commands
// - restore commands still copy storage into wiper registers when protected
// - preset rising edge reloads both wiper registers from storage
// - storage holds midscale 512 until user writes a new value
// - shifted word executes only when select rises back high
// - ready is active-high open drain, flags commands 2,3,8,9,10 and preset
// - serial input sampled on rising link clock, one bit, MSB first
// - serial out returns earlier input delayed 24 bits for daisy chain
// - channel one wiper at address 0x0, channel two at 0x1
module ppc_top (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_SCLK,
  input  wire logic        I_SERIAL_IN,
  input  wire logic        I_SELECT_N,
  input  wire logic        I_PROTECT_N,
  input  wire logic        I_PRESET_STROBE,
  output logic             O_SERIAL_OUT,
  output logic             O_READY_OUT,
  output logic             O_READY_OE_N,
  output logic             O_IRQ,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic sclk_s;
  logic sin_s;
  logic sel_s;
  logic prot_s;
  logic pre_s;

  ppc_sync #(.RST_VAL(1'b0)) u_sclk (.i_clk(I_CORE_CLK), .i_rst_n(I_RST_N), .i_d(I_SCLK),          .o_q(sclk_s));
  ppc_sync #(.RST_VAL(1'b0)) u_sin  (.i_clk(I_CORE_CLK), .i_rst_n(I_RST_N), .i_d(I_SERIAL_IN),     .o_q(sin_s));
  ppc_sync #(.RST_VAL(1'b1)) u_sel  (.i_clk(I_CORE_CLK), .i_rst_n(I_RST_N), .i_d(I_SELECT_N),      .o_q(sel_s));
  ppc_sync #(.RST_VAL(1'b1)) u_prot (.i_clk(I_CORE_CLK), .i_rst_n(I_RST_N), .i_d(I_PROTECT_N),     .o_q(prot_s));
  ppc_sync #(.RST_VAL(1'b1)) u_pre  (.i_clk(I_CORE_CLK), .i_rst_n(I_RST_N), .i_d(I_PRESET_STROBE), .o_q(pre_s));

  ////////////////////////////////////////////////////////////////////////
  // serial shifter and edge detect
  logic        sclk_d;
  logic        sel_d;
  logic        pre_d;
  logic [23:0] shift;
  logic [23:0] next_shift;
  logic        sout;
  logic        next_sout;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        sel_rise;
  logic        pre_rise;

  assign sclk_rise = sclk_s & ~sclk_d;
  assign sclk_fall = ~sclk_s & sclk_d;
  assign sel_rise  = sel_s & ~sel_d;
  assign pre_rise  = pre_s & ~pre_d;

  always_comb begin
    next_shift = shift;
    next_sout  = sout;
    if (!sel_s && sclk_rise) begin
      next_shift = {shift[22:0], sin_s};
    end
    if (!sel_s && sclk_fall) begin
      next_sout = shift[23];
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sclk_d <= 1'b0;
      sel_d  <= 1'b1;
      pre_d  <= 1'b1;
      shift  <= 24'h000000;
      sout   <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      sel_d  <= sel_s;
      pre_d  <= pre_s;
      shift  <= next_shift;
      sout   <= next_sout;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command execution, storage and ready
  ppc_pkg::ppc_word_t   word;
  ppc_pkg::ppc_state_t  state;
  ppc_pkg::ppc_state_t  next_state;
  logic [9:0]  wiper [2];
  logic [9:0]  next_wiper [2];
  logic [9:0]  nv [2];
  logic [9:0]  next_nv [2];
  logic [23:0] last_word;
  logic [23:0] next_last_word;
  logic [15:0] busy_cnt;
  logic [15:0] next_busy_cnt;
  logic        ch;
  logic        addr_ok;
  logic        ev_blocked;
  logic        start_op;
  logic        done_now;
  logic        ev_done;

  assign word = ppc_pkg::ppc_word_t'(shift);
  assign addr_ok = (word.addr == `PPC_ADDR_CH0) || (word.addr == `PPC_ADDR_CH1);
  assign ch      = (word.addr == `PPC_ADDR_CH1);

  always_comb begin
    next_state     = state;
    next_wiper     = wiper;
    next_nv        = nv;
    next_last_word = last_word;
    next_busy_cnt  = busy_cnt;
    ev_blocked     = 1'b0;
    start_op       = 1'b0;
    ev_done        = 1'b0;
    if (pre_rise) begin
      next_wiper[0] = nv[0];
      next_wiper[1] = nv[1];
      start_op      = 1'b1;
    end else if (sel_rise) begin
      next_last_word = shift;
      unique case (word.cmd)
        `PPC_CMD_RESTORE1,
        `PPC_CMD_RESTORE8: begin
          if (addr_ok) begin
            next_wiper[ch] = nv[ch];
          end
          start_op = (word.cmd == `PPC_CMD_RESTORE8);
        end
        `PPC_CMD_STORE: begin
          if (!prot_s) begin
            ev_blocked = 1'b1;
          end else begin
            if (addr_ok) begin
              next_nv[ch] = wiper[ch];
            end
            start_op = 1'b1;
          end
        end
        `PPC_CMD_WR_NV: begin
          if (!prot_s) begin
            ev_blocked = 1'b1;
          end else begin
            if (addr_ok) begin
              next_nv[ch] = word.data;
            end
            start_op = 1'b1;
          end
        end
        `PPC_CMD_WRITE: begin
          if (!prot_s) begin
            ev_blocked = 1'b1;
          end else if (addr_ok) begin
            next_wiper[ch] = word.data;
          end
        end
        `PPC_CMD_READ_NV,
        `PPC_CMD_READ_WIP: begin
          start_op = 1'b1;
        end
        default: begin
        end
      endcase
    end
    unique case (state)
      ppc_pkg::PPC_IDLE: begin
        if (start_op) begin
          next_state    = ppc_pkg::PPC_BUSY;
          next_busy_cnt = 16'(`PPC_NV_WRITE_CYC);
        end
      end
      ppc_pkg::PPC_BUSY: begin
        if (busy_cnt <= 16'h0001 || done_now) begin
          next_state    = ppc_pkg::PPC_IDLE;
          next_busy_cnt = 16'h0000;
          ev_done       = 1'b1;
        end else begin
          next_busy_cnt = busy_cnt - 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state     <= ppc_pkg::PPC_IDLE;
      wiper[0]  <= `PPC_MIDSCALE;
      wiper[1]  <= `PPC_MIDSCALE;
      nv[0]     <= `PPC_MIDSCALE;
      nv[1]     <= `PPC_MIDSCALE;
      last_word <= 24'h000000;
      busy_cnt  <= 16'h0000;
    end else begin
      state     <= next_state;
      wiper     <= next_wiper;
      nv        <= next_nv;
      last_word <= next_last_word;
      busy_cnt  <= next_busy_cnt;
    end
  end

  assign O_READY_OUT  = 1'b0;
  assign O_READY_OE_N = (state == ppc_pkg::PPC_IDLE);
  assign O_SERIAL_OUT = sout;

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait state
  logic        ap_wr;
  logic        ap_rd;
  logic        dp_wr;
  logic        next_dp_wr;
  logic [7:0]  dp_addr;
  logic [7:0]  next_dp_addr;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [3:0]  irq_stat;
  logic [3:0]  next_irq_stat;
  logic [3:0]  irq_mask;
  logic [3:0]  next_irq_mask;
  logic        ctrl_done;
  logic        next_ctrl_done;
  logic [3:0]  ev_vec;

  assign ap_wr = HSEL & HREADY & HTRANS[1] & HWRITE;
  assign ap_rd = HSEL & HREADY & HTRANS[1] & ~HWRITE;
  assign ev_vec = {ev_blocked, ev_done, pre_rise, sel_rise};
  // software can cut a busy phase short
  assign done_now = ctrl_done;

  always_comb begin
    next_dp_wr     = ap_wr;
    next_dp_addr   = ap_wr ? HADDR[7:0] : dp_addr;
    next_rdata     = rdata;
    next_irq_mask  = irq_mask;
    next_ctrl_done = 1'b0;
    next_irq_stat  = irq_stat;
    if (dp_wr) begin
      unique case (dp_addr)
        `PPC_OFF_CTRL:     next_ctrl_done = HWDATA[`PPC_CTRL_DONE_NOW];
        `PPC_OFF_IRQ_STAT: next_irq_stat  = irq_stat & ~HWDATA[3:0];
        `PPC_OFF_IRQ_MASK: next_irq_mask  = HWDATA[3:0];
        default: begin
        end
      endcase
    end
    // set wins over clear
    next_irq_stat = next_irq_stat | ev_vec;
    if (ap_rd) begin
      unique case (HADDR[7:0])
        `PPC_OFF_STATUS:    next_rdata = {28'h0000000, ~prot_s, ~sel_s, pre_s, (state == ppc_pkg::PPC_BUSY)};
        `PPC_OFF_IRQ_STAT:  next_rdata = {28'h0000000, irq_stat};
        `PPC_OFF_IRQ_MASK:  next_rdata = {28'h0000000, irq_mask};
        `PPC_OFF_WIPER0:    next_rdata = {22'h000000, wiper[0]};
        `PPC_OFF_WIPER1:    next_rdata = {22'h000000, wiper[1]};
        `PPC_OFF_NV0:       next_rdata = {22'h000000, nv[0]};
        `PPC_OFF_NV1:       next_rdata = {22'h000000, nv[1]};
        `PPC_OFF_LAST_WORD: next_rdata = {8'h00, last_word};
        default:            next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      dp_wr     <= 1'b0;
      dp_addr   <= 8'h00;
      rdata     <= 32'h00000000;
      irq_stat  <= 4'h0;
      irq_mask  <= 4'h0;
      ctrl_done <= 1'b0;
    end else begin
      dp_wr     <= next_dp_wr;
      dp_addr   <= next_dp_addr;
      rdata     <= next_rdata;
      irq_stat  <= next_irq_stat;
      irq_mask  <= next_irq_mask;
      ctrl_done <= next_ctrl_done;
    end
  end

  assign HRDATA    = rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign O_IRQ     = |(irq_stat & irq_mask);

endmodule

`default_nettype wire

// ---- test/ppc_checker.sv ----
/*
 * Port-level checks for ppc_top, bound into the design.
 * Assumes one core clock domain and an async active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module ppc_checker (
  input wire logic        I_CORE_CLK,
  input wire logic        I_RST_N,
  input wire logic        I_SCLK,
  input wire logic        I_SELECT_N,
  input wire logic        I_PRESET_STROBE,
  input wire logic        O_SERIAL_OUT,
  input wire logic        O_READY_OUT,
  input wire logic        O_READY_OE_N,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP
);
  logic [7:0] evt_cnt;
  logic [7:0] fall_cnt;
  logic [8:0] busy_cnt;
  // saturating ages; pins pass two flops so effects lag a few cycles
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      evt_cnt  <= 8'hFF;
      fall_cnt <= 8'hFF;
      busy_cnt <= 9'h000;
    end else begin
      evt_cnt  <= ($rose(I_SELECT_N) || $rose(I_PRESET_STROBE)) ? 8'h00 : evt_cnt + {7'h00, evt_cnt != 8'hFF};
      fall_cnt <= $fell(I_SCLK) ? 8'h00 : fall_cnt + {7'h00, fall_cnt != 8'hFF};
      busy_cnt <= O_READY_OE_N ? 9'h000 : busy_cnt + {8'h00, busy_cnt != 9'h1FF};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  a_ready_data_low: assert property (O_READY_OUT == 1'b0)
    else $error("ready data pin not low");
  a_busy_cause: assert property ($fell(O_READY_OE_N) |-> evt_cnt <= 8'h08)
    else $error("busy without select or preset rise");
  a_busy_hold: assert property ($fell(O_READY_OE_N) |-> !O_READY_OE_N [*3])
    else $error("busy released too soon");
  a_busy_bound: assert property (busy_cnt <= 9'h0C9)
    else $error("busy longer than write time");
  a_sout_on_fall: assert property ($changed(O_SERIAL_OUT) |-> fall_cnt <= 8'h06)
    else $error("serial out moved off a link fall");
  a_unmapped_zero: assert property (HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR > 32'h20 |=> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_resp_okay: assert property (HRESP == 1'b0)
    else $error("response not okay");
  a_ready_high: assert property (HREADYOUT == 1'b1)
    else $error("wait state inserted");
  c_busy: cover property ($fell(O_READY_OE_N));
  c_preset: cover property ($rose(I_PRESET_STROBE));
  c_select: cover property ($rose(I_SELECT_N));
endmodule
bind ppc_top ppc_checker i_chk (.I_CORE_CLK, .I_RST_N, .I_SCLK, .I_SELECT_N, .I_PRESET_STROBE, .O_SERIAL_OUT,
  .O_READY_OUT, .O_READY_OE_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY, .HRDATA, .HREADYOUT, .HRESP);
`default_nettype wire

// ---- test/ppc_host.sv ----
/*
 * Host serial master model: select, link clock and serial data.
 * Assumes the core clock; link period is 25 core cycles (125 ns).
 */
`timescale 1ns/10ps
`default_nettype none
module ppc_host (
  input  wire logic i_clk,
  input  wire logic i_sout,
  output logic      o_sclk,
  output logic      o_sdi,
  output logic      o_sel_n
);
  initial begin
    o_sclk  = 1'b0;
    o_sdi   = 1'b1;
    o_sel_n = 1'b1;
  end
  task automatic half(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic send(input ppc_pkg::ppc_word_t w, output logic [23:0] rx);
    o_sel_n <= 1'b0;
    half(13);
    for (int i = 23; i >= 0; i--) begin
      o_sdi  <= w[i];
      half(12);
      o_sclk <= 1'b1;
      rx[i]  = i_sout;
      half(13);
      o_sclk <= 1'b0;
    end
    half(13);
    // line released: show the inverse, never a stale bit
    o_sdi   <= ~o_sdi;
    o_sel_n <= 1'b1;
    half(25);
  endtask
endmodule
`default_nettype wire

// ---- test/ppc_top_tb.sv ----
/*
 * Self-checking bench for ppc_top with the host serial model.
 * Assumes 200 MHz core clock and the register offsets in ppc_defs.svh.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ppc_defs.svh"
module ppc_top_tb;
  logic               clk, rst_n, sclk, serial_in, sel_n, prot_n, preset, hsel, hwrite, have_prev;
  logic               sout, rdy, rdy_oe_n, irq, hready, hresp;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [31:0]        haddr, hwdata, hrdata, rd;
  logic [23:0]        rx;
  logic [9:0]         v0, v1;
  logic [3:0]         cmds [5];
  int                 bad_count, n_compared;
  ppc_pkg::ppc_word_t w, prev;
  ppc_top i_dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_SCLK(sclk), .I_SERIAL_IN(serial_in), .I_SELECT_N(sel_n),
    .I_PROTECT_N(prot_n), .I_PRESET_STROBE(preset), .O_SERIAL_OUT(sout), .O_READY_OUT(rdy),
    .O_READY_OE_N(rdy_oe_n), .O_IRQ(irq), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp));
  ppc_host i_host (.i_clk(clk), .i_sout(sout), .o_sclk(sclk), .o_sdi(serial_in), .o_sel_n(sel_n));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h000000, a};
    hsize  <= 3'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic tx(input logic [3:0] c, input logic [3:0] a, input logic [9:0] d);
    w = '{cmd: c, addr: a, spare: 6'h00, data: d};
    i_host.send(w, rx);
    if (have_prev) chk({8'h00, rx}, {8'h00, prev});
    prev      = w;
    have_prev = 1'b1;
  endtask
  task automatic wait_ready;
    for (int t = 0; t < 300 && rdy_oe_n !== 1'b1; t++) @(posedge clk);
    chk(rdy_oe_n, 1'b1);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [9:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd, {22'h000000, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    finish_test();
  end
  initial begin
    {rst_n, hsel, hwrite, have_prev, htrans, hsize, haddr, hwdata, bad_count, n_compared} = '0;
    {prot_n, preset} = 2'h3;
    cmds = '{`PPC_CMD_STORE, `PPC_CMD_WR_NV, `PPC_CMD_RESTORE8, `PPC_CMD_READ_NV, `PPC_CMD_READ_WIP};
    void'($urandom(32'hD7BF));
    // odd v0 and even v1 below 512 keep both apart from each other and from midscale
    v0 = 10'($urandom) | 10'h001;
    v1 = 10'($urandom) & 10'h1FE;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 16; a < 32; a += 4) rdchk(8'(a), `PPC_MIDSCALE);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, `PPC_OFF_IRQ_MASK, 32'hF);
    tx(`PPC_CMD_WRITE, `PPC_ADDR_CH0, v0);
    tx(`PPC_CMD_WRITE, `PPC_ADDR_CH1, v1);
    rdchk(`PPC_OFF_WIPER0, v0);
    rdchk(`PPC_OFF_WIPER1, v1);
    chk(irq, 1'b1);
    for (int i = 0; i < 5; i++) begin
      tx(cmds[i], `PPC_ADDR_CH1, i == 1 ? v0 : 10'h000);
      chk(rdy_oe_n, 1'b0);
      if (i == 0) ahb(1'b1, `PPC_OFF_CTRL, 32'h1);
      wait_ready();
    end
    rdchk(`PPC_OFF_NV1, v0);
    tx(`PPC_CMD_WRITE, `PPC_ADDR_CH1, v1);
    prot_n <= 1'b0;
    tx(`PPC_CMD_WRITE, `PPC_ADDR_CH0, v1);
    rdchk(`PPC_OFF_WIPER0, v0);
    ahb(1'b0, `PPC_OFF_STATUS, 32'h0);
    chk(rd, 32'h0000000A);
    ahb(1'b0, `PPC_OFF_LAST_WORD, 32'h0);
    chk(rd, {8'h00, `PPC_CMD_WRITE, `PPC_ADDR_CH0, 6'h00, v1});
    tx(`PPC_CMD_STORE, `PPC_ADDR_CH0, 10'h000);
    rdchk(`PPC_OFF_NV0, `PPC_MIDSCALE);
    tx(`PPC_CMD_RESTORE8, `PPC_ADDR_CH1, 10'h000);
    wait_ready();
    rdchk(`PPC_OFF_WIPER1, v0);
    tx(`PPC_CMD_RESTORE1, `PPC_ADDR_CH0, 10'h000);
    rdchk(`PPC_OFF_WIPER0, `PPC_MIDSCALE);
    tx(`PPC_CMD_NOP, `PPC_ADDR_CH0, 10'h000);
    prot_n <= 1'b1;
    tx(`PPC_CMD_WRITE, `PPC_ADDR_CH0, v1);
    tx(`PPC_CMD_WRITE, `PPC_ADDR_CH1, v1);
    preset <= 1'b0;
    repeat (8) @(posedge clk);
    preset <= 1'b1;
    repeat (8) @(posedge clk);
    chk(rdy_oe_n, 1'b0);
    wait_ready();
    rdchk(`PPC_OFF_WIPER0, `PPC_MIDSCALE);
    rdchk(`PPC_OFF_WIPER1, v0);
    rdchk(`PPC_OFF_IRQ_STAT, 10'h00F);
    ahb(1'b1, `PPC_OFF_IRQ_STAT, 32'hF);
    ahb(1'b1, `PPC_OFF_IRQ_MASK, 32'h0);
    tx(`PPC_CMD_NOP, `PPC_ADDR_CH0, 10'h000);
    chk(irq, 1'b0);
    ahb(1'b1, `PPC_OFF_IRQ_MASK, 32'h1);
    @(posedge clk);
    chk(irq, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
